/* File: shared/instruction_cycle_timing_map.vh */
/*
 * Constants for the instruction cycle timing unit: widths, decode word layout,
 * cycle limits and reset values. Included by the design file only.
 */
`ifndef INSTRUCTION_CYCLE_TIMING_MAP_VH
`define INSTRUCTION_CYCLE_TIMING_MAP_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define ICT_BYTE_W 8
`define ICT_LEN_W 2
`define ICT_CYC_W 4

// ----------------------------------------------------------------------------
// Decode word layout: {cond, length, cycles}
// ----------------------------------------------------------------------------
`define ICT_DEC_W 7
`define ICT_DEC_COND 6
`define ICT_DEC_LEN_MSB 5
`define ICT_DEC_LEN_LSB 4
`define ICT_DEC_CYC_MSB 3
`define ICT_DEC_CYC_LSB 0

// ----------------------------------------------------------------------------
// Limits
// ----------------------------------------------------------------------------
`define ICT_MAX_CYCLES 4'h8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ICT_RST_OPCODE 8'h00
`define ICT_RST_LEN 2'h0
`define ICT_RST_CYC 4'h0
`define ICT_RST_READY 1'b1

`endif

/* File: src/instruction_cycle_timing.v */
/*
 * Instruction cycle timing unit: takes one program byte per clock, decodes
 * each opcode to its byte length and its execution time in clocks, consumes
 * the operand bytes and marks start and end of every instruction.
 * Assumes the fetch stage and the branch condition logic run on I_SYS_CLK,
 * that operand bytes follow their opcode on the stream in program order,
 * and that the branch condition is settled at the edge that ends the
 * next-to-last clock of a conditional branch.
 */
// Contract
// RL1 - Time counted in plain clocks, no machine cycles
// RL2 - Most instructions: cycles equal byte length
// RL3 - Untaken conditional branch one clock shorter
// RL4 - Register-accumulator arithmetic and logic: 1 byte, 1
// RL5 - Pointer-addressed RAM accumulator ops: 1 byte, 2
// RL6 - Accumulator with direct or immediate: 2, 2
// RL7 - Accumulator into direct byte logic: 2, 2
// RL8 - Immediate into direct byte logic: 3, 3
// RL9 - Accumulator-only operations: 1 byte, 1 cycle
// RL10 - Code byte read: 1 byte, 3 cycles
// RL11 - External data move: 1 byte, 3 cycles
// RL12 - Data pointer immediate load: 3, 3
// RL13 - Direct to direct move: 3, 3
// RL14 - Accumulator to pointer-addressed RAM: 1, 2
// RL15 - Direct or immediate to pointer RAM: 2, 2
// RL16 - Direct or immediate to working register: 2, 2
// RL17 - Push and pop direct: 2, 2
// RL18 - Exchange working register with accumulator: 1, 1
// RL19 - Nibble or byte exchange with pointer RAM: 1, 2
// RL20 - Carry ops 1/1, direct bit ops 2/2
// RL21 - No instruction exceeds eight clocks
// RL22 - Unused opcode behaves as no-operation
// RL23 - Operand bytes arrive one per clock
`timescale 1ns/1ps
`include "instruction_cycle_timing_map.vh"

module instruction_cycle_timing (
    // Clock and reset
    input wire I_SYS_CLK,
    input wire I_ARST_N,
    // Program byte stream
    input wire [7:0] I_CODE_BYTE,
    input wire I_CODE_VALID,
    output reg O_CODE_READY,
    // Branch condition of the current conditional branch
    input wire I_BRANCH_TAKEN,
    // Instruction status
    output reg O_START,
    output reg O_DONE,
    output reg O_BUSY,
    output reg [7:0] O_OPCODE,
    output reg [1:0] O_LENGTH,
    output reg [3:0] O_CYCLES,
    output reg [3:0] O_CYCLE_NUM,
    output reg O_BRANCH_EXT,
    // Operand bytes
    output reg [7:0] O_OPERAND,
    output reg O_OPERAND_VALID,
    output reg O_FETCH_STALL
);

    // ------------------------------------------------------------------------
    // Decode table: {cond, length, not-taken cycles}
    // ------------------------------------------------------------------------
    // Packs one table entry
    function [`ICT_DEC_W-1:0] mk;
        input c;
        input [1:0] l;
        input [3:0] n;
        begin
            mk = {c, l, n};
        end
    endfunction

    // Clocks are the untaken figure; a taken branch adds one at run time
    function [`ICT_DEC_W-1:0] decode;
        input [7:0] op;
        reg [3:0] hi;
        reg [3:0] lo;
        begin
            hi = op[7:4];
            lo = op[3:0];
            decode = mk(1'b0, 2'h1, 4'h1);
            if (lo[3]) begin
                // Working register column
                case (hi)
                    4'h2, 4'h3, 4'h9: decode = mk(1'b0, 2'h1, 4'h1); // [RL4]
                    4'h4, 4'h5, 4'h6: decode = mk(1'b0, 2'h1, 4'h1); // [RL4]
                    4'h7, 4'h8, 4'hA: decode = mk(1'b0, 2'h2, 4'h2); // [RL16] [RL2]
                    4'hB: decode = mk(1'b1, 2'h3, 4'h3); // [RL3]
                    4'hC: decode = mk(1'b0, 2'h1, 4'h1); // [RL18]
                    4'hD: decode = mk(1'b1, 2'h2, 4'h2); // [RL3]
                    default: decode = mk(1'b0, 2'h1, 4'h1); // [RL2]
                endcase
            end else if (lo[3:1] == 3'h3) begin
                // Pointer-addressed ram column
                case (hi)
                    4'h7, 4'h8, 4'hA: decode = mk(1'b0, 2'h2, 4'h2); // [RL15]
                    4'hB: decode = mk(1'b1, 2'h3, 4'h4); // [RL3]
                    4'hC, 4'hD: decode = mk(1'b0, 2'h1, 4'h2); // [RL19]
                    4'hF: decode = mk(1'b0, 2'h1, 4'h2); // [RL14]
                    4'h0, 4'h1, 4'h2, 4'h3: decode = mk(1'b0, 2'h1, 4'h2); // [RL5]
                    4'h4, 4'h5, 4'h6, 4'h9: decode = mk(1'b0, 2'h1, 4'h2); // [RL5]
                    default: decode = mk(1'b0, 2'h1, 4'h2); // [RL5]
                endcase
            end else if (lo == 4'h5) begin
                // Direct byte column
                case (hi)
                    4'h7, 4'h8: decode = mk(1'b0, 2'h3, 4'h3); // [RL13]
                    4'hA: decode = mk(1'b0, 2'h1, 4'h1); // [RL22]
                    4'hB, 4'hD: decode = mk(1'b1, 2'h3, 4'h3); // [RL3]
                    default: decode = mk(1'b0, 2'h2, 4'h2); // [RL6] [RL2]
                endcase
            end else if (lo == 4'h4) begin
                // Accumulator and immediate column
                case (hi)
                    4'h8: decode = mk(1'b0, 2'h1, 4'h8); // [RL21]
                    4'hA: decode = mk(1'b0, 2'h1, 4'h4);
                    4'hB: decode = mk(1'b1, 2'h3, 4'h3); // [RL3]
                    4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: decode = mk(1'b0, 2'h1, 4'h1); // [RL9]
                    default: decode = mk(1'b0, 2'h2, 4'h2); // [RL6]
                endcase
            end else if (lo == 4'h3) begin
                // Rotates, code reads, external moves and carry ops
                case (hi)
                    4'h4, 4'h5, 4'h6: decode = mk(1'b0, 2'h3, 4'h3); // [RL8]
                    4'h7: decode = mk(1'b0, 2'h1, 4'h3);
                    4'h8, 4'h9: decode = mk(1'b0, 2'h1, 4'h3); // [RL10]
                    4'hE, 4'hF: decode = mk(1'b0, 2'h1, 4'h3); // [RL11]
                    4'hB, 4'hC, 4'hD: decode = mk(1'b0, 2'h1, 4'h1); // [RL20]
                    default: decode = mk(1'b0, 2'h1, 4'h1); // [RL9]
                endcase
            end else if (lo == 4'h2) begin
                // Long transfers, returns, logic into direct and bit ops
                case (hi)
                    4'h0, 4'h1: decode = mk(1'b0, 2'h3, 4'h4);
                    4'h2, 4'h3: decode = mk(1'b0, 2'h1, 4'h5);
                    4'hE, 4'hF: decode = mk(1'b0, 2'h1, 4'h3); // [RL11]
                    4'h4, 4'h5, 4'h6: decode = mk(1'b0, 2'h2, 4'h2); // [RL7]
                    default: decode = mk(1'b0, 2'h2, 4'h2); // [RL20]
                endcase
            end else if (lo == 4'h1) begin
                // Absolute jumps and calls
                decode = mk(1'b0, 2'h2, 4'h3);
            end else begin
                // Relative and bit branches, long loads, stack and no-operation
                case (hi)
                    4'h0: decode = mk(1'b0, 2'h1, 4'h1);
                    4'h1, 4'h2, 4'h3: decode = mk(1'b1, 2'h3, 4'h3); // [RL3]
                    4'h4, 4'h5, 4'h6, 4'h7: decode = mk(1'b1, 2'h2, 4'h2); // [RL3]
                    4'h8: decode = mk(1'b0, 2'h2, 4'h3);
                    4'h9: decode = mk(1'b0, 2'h3, 4'h3); // [RL12]
                    4'hE, 4'hF: decode = mk(1'b0, 2'h1, 4'h3); // [RL11]
                    4'hA, 4'hB: decode = mk(1'b0, 2'h2, 4'h2); // [RL20]
                    default: decode = mk(1'b0, 2'h2, 4'h2); // [RL17]
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg busy_q, busy_d;
    // Conditional branch flag and its taken extension
    reg cond_q, cond_d;
    reg ext_q, ext_d;
    reg [1:0] len_q, len_d;
    reg [3:0] total_q, total_d;
    // Clock of the running instruction, 1 up to the total
    reg [3:0] cnt_q, cnt_d;
    reg [7:0] opcode_q, opcode_d;
    reg [7:0] operand_q, operand_d;
    reg ready_d, start_d, done_d, opv_d, stall_d;
    // Combinational helpers
    reg [`ICT_DEC_W-1:0] dec;
    reg adv;
    reg last;

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always @* begin
        // Hold the state and keep the pulses low by default
        busy_d = busy_q;
        cond_d = cond_q;
        ext_d = ext_q;
        len_d = len_q;
        total_d = total_q;
        cnt_d = cnt_q;
        opcode_d = opcode_q;
        operand_d = operand_q;
        start_d = 1'b0;
        done_d = 1'b0;
        opv_d = 1'b0;
        stall_d = 1'b0;
        adv = 1'b0;
        dec = decode(I_CODE_BYTE);
        // Last clock of the running instruction
        last = busy_q && (cnt_q == total_q);
        if (busy_q && (cnt_q < {2'h0, len_q})) begin
            // Operand byte expected in this very clock
            if (I_CODE_VALID) begin // [RL23]
                operand_d = I_CODE_BYTE;
                opv_d = 1'b1;
                adv = 1'b1;
            end else begin
                // Missing operand: hold the count, no time passes
                stall_d = 1'b1;
            end
        end else if (busy_q && !last) begin
            // Execute-only clock: time passes with no byte taken
            adv = 1'b1;
        end
        if (adv) begin
            cnt_d = cnt_q + 4'h1; // [RL1]
            // Taken branch costs one more clock than the untaken path
            if (cond_q && !ext_q && (cnt_q == total_q - 4'h1) && I_BRANCH_TAKEN) begin // [RL3]
                total_d = total_q + 4'h1;
                ext_d = 1'b1;
            end
        end
        if (last) begin
            done_d = 1'b1;
            busy_d = 1'b0;
        end
        // The next opcode is taken in the last clock, so one-clock ops run
        // back to back and no clock is lost between instructions
        if (I_CODE_VALID && O_CODE_READY && (!busy_q || last)) begin
            busy_d = 1'b1;
            cnt_d = 4'h1;
            opcode_d = I_CODE_BYTE;
            cond_d = dec[`ICT_DEC_COND];
            len_d = dec[`ICT_DEC_LEN_MSB:`ICT_DEC_LEN_LSB];
            total_d = dec[`ICT_DEC_CYC_MSB:`ICT_DEC_CYC_LSB]; // [RL2]
            // A new opcode drops any taken-branch extension
            ext_d = 1'b0;
            start_d = 1'b1;
        end
        // Keep the total in range even when a taken branch adds its clock
        if (total_d > `ICT_MAX_CYCLES) begin
            total_d = `ICT_MAX_CYCLES; // [RL21]
        end
        // Refuse the stream only in execute-only clocks, so no byte is dropped
        ready_d = !busy_d || (cnt_d < {2'h0, len_d}) || (cnt_d == total_d);
    end

    always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            busy_q <= 1'b0;
            cond_q <= 1'b0;
            ext_q <= 1'b0;
            len_q <= `ICT_RST_LEN;
            total_q <= `ICT_RST_CYC;
            cnt_q <= `ICT_RST_CYC;
            opcode_q <= `ICT_RST_OPCODE;
            operand_q <= 8'h00;
            O_CODE_READY <= `ICT_RST_READY;
            O_START <= 1'b0;
            O_DONE <= 1'b0;
            O_OPERAND_VALID <= 1'b0;
            O_FETCH_STALL <= 1'b0;
        end else begin
            busy_q <= busy_d;
            cond_q <= cond_d;
            ext_q <= ext_d;
            len_q <= len_d;
            total_q <= total_d;
            cnt_q <= cnt_d;
            opcode_q <= opcode_d;
            operand_q <= operand_d;
            O_CODE_READY <= ready_d;
            O_START <= start_d;
            O_DONE <= done_d;
            O_OPERAND_VALID <= opv_d;
            O_FETCH_STALL <= stall_d;
        end
    end

    // ------------------------------------------------------------------------
    // Status outputs, registered copies of the state
    // ------------------------------------------------------------------------
    // Fed from the next-state values so they line up with the state registers
    always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_BUSY <= 1'b0;
            O_OPCODE <= `ICT_RST_OPCODE;
            O_LENGTH <= `ICT_RST_LEN;
            O_CYCLES <= `ICT_RST_CYC;
            O_CYCLE_NUM <= `ICT_RST_CYC;
            O_BRANCH_EXT <= 1'b0;
            O_OPERAND <= 8'h00;
        end else begin
            O_BUSY <= busy_d;
            O_OPCODE <= opcode_d;
            O_LENGTH <= len_d;
            O_CYCLES <= total_d;
            O_CYCLE_NUM <= cnt_d;
            O_BRANCH_EXT <= ext_d;
            O_OPERAND <= operand_d;
        end
    end

endmodule // instruction_cycle_timing

/* File: verif/prog_mem_model.sv */
/* Program memory model: offers one code byte per clock from a small array.
   Assumes the bench loads the array and restarts the pointer between runs. */
`timescale 1ns/1ps
module prog_mem_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Control from the bench
    input wire logic i_restart,
    input wire logic i_hold,
    input wire logic [7:0] i_count,
    // Byte stream
    input wire logic i_ready,
    output logic [7:0] o_byte,
    output logic o_valid
);
    logic [7:0] mem [0:15];
    logic [7:0] ptr_q;
    logic [7:0] last_q;

    // Operand bytes may be held back; outside a valid byte the bus shows junk
    assign o_valid = (ptr_q < i_count) && !(i_hold && ptr_q != 8'h00);
    assign o_byte = o_valid ? mem[ptr_q[3:0]] : ~last_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ptr_q <= 8'h00;
            last_q <= 8'h00;
        end else if (i_restart) begin
            ptr_q <= 8'h00;
        end else if (o_valid && i_ready) begin
            ptr_q <= ptr_q + 8'h01;
            last_q <= mem[ptr_q[3:0]];
        end
    end
endmodule  // prog_mem_model

/* File: verif/instruction_cycle_timing_chk.sv */
/* Checker for the instruction cycle timing unit, bound to its top ports.
   Assumes one clock domain with an active-low asynchronous reset. */
`timescale 1ns/1ps
module instruction_cycle_timing_chk (
    input wire I_SYS_CLK,
    input wire I_ARST_N,
    input wire O_CODE_READY,
    input wire O_START,
    input wire O_DONE,
    input wire O_BUSY,
    input wire [7:0] O_OPCODE,
    input wire [1:0] O_LENGTH,
    input wire [3:0] O_CYCLES,
    input wire [3:0] O_CYCLE_NUM,
    input wire O_BRANCH_EXT,
    input wire O_OPERAND_VALID,
    input wire O_FETCH_STALL
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);

    a_start_first: assert property (O_START |-> O_BUSY && O_CYCLE_NUM == 4'h1 && O_LENGTH != 2'h0)
        else $error("start without cycle one");
    a_cycles_max: assert property (O_BUSY |-> O_CYCLES != 4'h0 && O_CYCLES <= 4'h8)
        else $error("cycle total out of range");
    a_cycles_len: assert property (O_START |-> O_CYCLES >= {2'h0, O_LENGTH})
        else $error("fewer clocks than bytes");
    a_num_step: assert property (O_BUSY && O_CYCLE_NUM < O_CYCLES |=>
        O_CYCLE_NUM == $past(O_CYCLE_NUM) + 4'h1 || O_FETCH_STALL)
        else $error("cycle number skipped");
    a_done_last: assert property (O_BUSY && O_CYCLE_NUM == O_CYCLES |=> O_DONE)
        else $error("done missing after last cycle");
    a_ready_refuse: assert property (O_BUSY && O_CYCLE_NUM >= {2'h0, O_LENGTH} && O_CYCLE_NUM < O_CYCLES
        |-> !O_CODE_READY)
        else $error("byte accepted in execute cycle");
    a_operand_slot: assert property (O_OPERAND_VALID |-> $past(O_CYCLE_NUM) < {2'h0, $past(O_LENGTH)})
        else $error("operand outside operand cycles");
    a_branch_ext: assert property ($rose(O_BRANCH_EXT) |-> O_CYCLES == $past(O_CYCLES) + 4'h1)
        else $error("taken branch not one clock longer");
    a_unused_nop: assert property (O_START && O_OPCODE == 8'hA5 |-> O_LENGTH == 2'h1 && O_CYCLES == 4'h1)
        else $error("unused opcode not like no-operation");
    a_stall_hold: assert property (O_FETCH_STALL |-> O_CYCLE_NUM == $past(O_CYCLE_NUM))
        else $error("count moved during stall");

    c_taken: cover property ($rose(O_BRANCH_EXT));
    c_stall: cover property (O_FETCH_STALL);
    c_eight: cover property (O_START && O_CYCLES == 4'h8);
endmodule  // instruction_cycle_timing_chk

bind instruction_cycle_timing instruction_cycle_timing_chk u_instruction_cycle_timing_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .O_CODE_READY(O_CODE_READY), .O_START(O_START),
    .O_DONE(O_DONE), .O_BUSY(O_BUSY), .O_OPCODE(O_OPCODE), .O_LENGTH(O_LENGTH), .O_CYCLES(O_CYCLES),
    .O_CYCLE_NUM(O_CYCLE_NUM), .O_BRANCH_EXT(O_BRANCH_EXT), .O_OPERAND_VALID(O_OPERAND_VALID),
    .O_FETCH_STALL(O_FETCH_STALL)
);

/* File: verif/instruction_cycle_timing_tb.sv */
/* Testbench for the instruction cycle timing unit: length and clocks per opcode.
   Assumes the program memory model and the checker are compiled first. */
`timescale 1ns/1ps
module instruction_cycle_timing_tb;
    logic clk = 0, arst_n = 0, taken = 0, restart = 0, hold = 0;
    logic [7:0] count = 8'h00, code_byte, opcode, operand;
    logic code_valid, ready, start, done, busy, br_ext, op_valid, stall;
    logic [1:0] length;
    logic [3:0] cycles, cyc_num;
    int num_errors = 0, checked = 0;
    // Opcode, byte length, clocks
    logic [15:0] tbl [0:28] = '{16'h2811, 16'h9811, 16'h5811, 16'h2612, 16'h0612, 16'h2522, 16'h2422,
        16'h5222, 16'h6222, 16'h4333, 16'h6333, 16'hE411, 16'hC411, 16'hD411, 16'h9313, 16'h8313,
        16'hE213, 16'hF013, 16'h9033, 16'h8533, 16'hF612, 16'h7622, 16'h7822, 16'hC022, 16'hD022,
        16'hC811, 16'hD612, 16'hD222, 16'h8418};

    initial forever #5 clk = ~clk;

    instruction_cycle_timing u_instruction_cycle_timing (
        .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_CODE_BYTE(code_byte), .I_CODE_VALID(code_valid),
        .O_CODE_READY(ready), .I_BRANCH_TAKEN(taken), .O_START(start), .O_DONE(done), .O_BUSY(busy),
        .O_OPCODE(opcode), .O_LENGTH(length), .O_CYCLES(cycles), .O_CYCLE_NUM(cyc_num),
        .O_BRANCH_EXT(br_ext), .O_OPERAND(operand), .O_OPERAND_VALID(op_valid), .O_FETCH_STALL(stall));

    prog_mem_model u_prog_mem_model (
        .i_clk(clk), .i_arst_n(arst_n), .i_restart(restart), .i_hold(hold), .i_count(count),
        .i_ready(ready), .o_byte(code_byte), .o_valid(code_valid));

    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic load(logic [7:0] b0, logic [7:0] b1, logic [7:0] b2, logic [7:0] n, logic tk, logic hd);
        @(posedge clk);
        restart <= 1;
        count <= 8'h00;
        u_prog_mem_model.mem[0] = b0;
        u_prog_mem_model.mem[1] = b1;
        u_prog_mem_model.mem[2] = b2;
        @(posedge clk);
        restart <= 0;
        count <= n;
        taken <= tk;
        hold <= hd;
    endtask

    // One instruction: length, total and clocks from start to done
    task automatic run_op(logic [7:0] op, int len, int cyc, logic tk, int st);
        int n;
        logic seen;
        int nv;
        load(op, 8'h5B, 8'h5C, 8'(len), tk, st != 0);
        n = 0;
        seen = 0;
        nv = 0;
        while (start !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check("start", 8'h01, {7'h00, start});
        check("opcode", op, opcode);
        check("length", 8'(len), {6'h00, length});
        check("cycles", 8'(cyc), {4'h0, cycles});
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk);
            if (n + 1 >= st) hold <= 0;
            n++;
            @(negedge clk);
            seen = seen | (stall === 1'b1);
            nv += (op_valid === 1'b1);
        end
        check("clocks", 8'(cyc + tk + st), 8'(n));
        check("stall seen", {7'h00, st != 0}, {7'h00, seen});
        check("operands", 8'(len - 1), 8'(nv));
        check("branch ext", {7'h00, tk}, {7'h00, br_ext});
        check("cycles end", 8'(cyc + tk), {4'h0, cycles});
        if (len > 1) check("operand", (len == 3) ? 8'h5C : 8'h5B, operand);
    endtask

    // Three one-clock instructions must start on three consecutive clocks
    task automatic back_to_back();
        load(8'hE4, 8'hC4, 8'hA5, 8'h03, 0, 0);
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            check("start", 8'h01, {7'h00, start});
            check("opcode", u_prog_mem_model.mem[i], opcode);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1;
        @(negedge clk);
        check("ready", 8'h01, {7'h00, ready});
        check("busy", 8'h00, {7'h00, busy});
        back_to_back();
        foreach (tbl[i]) run_op(tbl[i][15:8], tbl[i][7:4], tbl[i][3:0], 0, 0);
        run_op(8'h82, 2, 2, 0, 0);
        run_op(8'hC3, 1, 1, 0, 0);
        run_op(8'h40, 2, 2, 0, 0);
        run_op(8'h40, 2, 2, 1, 0);
        run_op(8'hB6, 3, 4, 1, 0);
        run_op(8'h75, 3, 3, 0, 2);
        stop_test();
    end

    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
endmodule  // instruction_cycle_timing_tb
